// ### bsl_host.sv
// host model: program flag loaded from sense replies
`timescale 1ns/1ns
module bsl_host
(
   input wire logic i_clock,
   input wire bsl_pkg::bsl_sense_rsp_t i_rsp,
   output logic o_flag
);
   always_ff @(posedge i_clock)
      if (i_rsp.valid)
         o_flag <= i_rsp.state;
endmodule : bsl_host

// ### bsl_link.sv
// binary signal link: held control lines, sense interrogation, interrupts
//
// How it works
// - control lines are held registered levels
// - one addressed line changes per command
// - 120 control lines in banks of eight
// - set command drives addressed line true
// - clear command drives addressed line false
// - sense command returns addressed line state
// - 120 sense inputs in banks of eight
// - one standard interrupt input interrupts host
// - single priority request passes straight through
// - several requests presented one by one, ordered
// - 64 priority inputs in groups of four
`timescale 1ns/1ns
module bsl_link
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire bsl_pkg::bsl_cmd_t i_cmd,
   output bsl_pkg::bsl_sense_rsp_t o_sense_rsp,
   output logic [bsl_pkg::NUM_CTRL-1:0] o_ctrl_line,
   input wire logic [bsl_pkg::NUM_SENSE-1:0] i_sense_line,
   input wire logic i_std_irq,
   output logic o_std_irq,
   input wire logic [bsl_pkg::NUM_PRIO-1:0] i_prio_req,
   input wire logic i_prio_ack,
   output logic o_prio_irq,
   output logic [bsl_pkg::PRIO_ID_W-1:0] o_prio_id
);
   typedef enum logic [1:0]
   {
      BSL_PI_IDLE = 2'b01,
      BSL_PI_PRESENT = 2'b10
   } bsl_pi_state_t;

   logic [bsl_pkg::NUM_SENSE-1:0] sense_meta;
   logic [bsl_pkg::NUM_SENSE-1:0] sense_sync;
   logic std_meta;
   logic std_sync;
   logic [bsl_pkg::NUM_PRIO-1:0] prio_meta;
   logic [bsl_pkg::NUM_PRIO-1:0] prio_sync;
   logic [bsl_pkg::NUM_PRIO-1:0] prio_prev;
   logic [bsl_pkg::NUM_PRIO-1:0] pending;
   logic [bsl_pkg::NUM_PRIO-1:0] next_pending;
   logic [bsl_pkg::NUM_PRIO-1:0] prio_rise;
   logic [bsl_pkg::NUM_PRIO-1:0] ack_clear;
   logic [bsl_pkg::NUM_CTRL-1:0] next_ctrl_line;
   bsl_pi_state_t pi_state;
   bsl_pi_state_t next_pi_state;
   logic arb_any;
   logic [bsl_pkg::PRIO_ID_W-1:0] arb_id;
   logic next_prio_irq;
   logic [bsl_pkg::PRIO_ID_W-1:0] next_prio_id;
   logic cmd_set;
   logic cmd_clear;
   logic cmd_sense;
   logic ctrl_addr_ok;
   logic sense_addr_ok;
   logic sense_bit;
   logic ack_taken;

   // pins from the patch panel are asynchronous to the clock
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         sense_meta <= '0;
         sense_sync <= '0;
      end
      else
      begin
         sense_meta <= i_sense_line;
         sense_sync <= sense_meta;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         std_meta <= 1'b0;
         std_sync <= 1'b0;
      end
      else
      begin
         std_meta <= i_std_irq;
         std_sync <= std_meta;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         prio_meta <= '0;
         prio_sync <= '0;
      end
      else
      begin
         prio_meta <= i_prio_req;
         prio_sync <= prio_meta;
      end
   end

   // command decode
   assign cmd_set = i_cmd.valid && (i_cmd.op == bsl_pkg::BSL_OP_SET);
   assign cmd_clear = i_cmd.valid && (i_cmd.op == bsl_pkg::BSL_OP_CLEAR);
   assign cmd_sense = i_cmd.valid && (i_cmd.op == bsl_pkg::BSL_OP_SENSE);
   assign ctrl_addr_ok = i_cmd.addr <= bsl_pkg::CTRL_LAST;
   assign sense_addr_ok = i_cmd.addr <= bsl_pkg::SENSE_LAST;
   assign sense_bit = sense_addr_ok ? sense_sync[i_cmd.addr] : 1'b0;

   // each control line only reacts to its own address
   genvar c;
   generate
      for (c = 0; c < bsl_pkg::NUM_CTRL; c++)
      begin : g_ctrl
         logic hit;
         assign hit = ctrl_addr_ok && (i_cmd.addr == 7'(c));
         assign next_ctrl_line[c] = (hit && cmd_set) ? 1'b1 :
                                    (hit && cmd_clear) ? 1'b0 :
                                    o_ctrl_line[c];
      end
   endgenerate

   // held levels: a line only moves on a command for its own address
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_ctrl_line <= '0;
      end
      else
      begin
         o_ctrl_line <= next_ctrl_line;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_sense_rsp <= '0;
         o_std_irq <= 1'b0;
      end
      else
      begin
         o_sense_rsp.valid <= cmd_sense;
         o_sense_rsp.state <= cmd_sense ? sense_bit : 1'b0;
         o_std_irq <= std_sync;
      end
   end

   // priority requests latch on a rising edge; ack retires the presented one
   assign prio_rise = prio_sync & ~prio_prev;
   assign ack_taken = (pi_state == BSL_PI_PRESENT) && i_prio_ack;

   genvar p;
   generate
      for (p = 0; p < bsl_pkg::NUM_PRIO; p++)
      begin : g_pend
         assign ack_clear[p] = ack_taken && (o_prio_id == 6'(p));
         // a new edge in the ack cycle wins over the clear
         assign next_pending[p] = prio_rise[p] | (pending[p] & ~ack_clear[p]);
      end
   endgenerate

   bsl_prio_arbiter u_arb
   (
      .i_pending(pending),
      .o_any(arb_any),
      .o_id(arb_id)
   );

   always_comb
   begin
      next_pi_state = pi_state;
      next_prio_irq = o_prio_irq;
      next_prio_id = o_prio_id;
      case (pi_state)
         BSL_PI_IDLE:
         begin
            if (arb_any)
            begin
               next_pi_state = BSL_PI_PRESENT;
               next_prio_irq = 1'b1;
               next_prio_id = arb_id;
            end
         end
         BSL_PI_PRESENT:
         begin
            if (i_prio_ack)
            begin
               next_pi_state = BSL_PI_IDLE;
               next_prio_irq = 1'b0;
            end
         end
         default:
         begin
            next_pi_state = BSL_PI_IDLE;
            next_prio_irq = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         prio_prev <= '0;
         pending <= '0;
         pi_state <= BSL_PI_IDLE;
         o_prio_irq <= 1'b0;
         o_prio_id <= '0;
      end
      else
      begin
         prio_prev <= prio_sync;
         pending <= next_pending;
         pi_state <= next_pi_state;
         o_prio_irq <= next_prio_irq;
         o_prio_id <= next_prio_id;
      end
   end
endmodule : bsl_link

// ### bsl_link_asserts.sv
// port assertions for the link
`timescale 1ns/1ns
module bsl_link_asserts
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire bsl_pkg::bsl_cmd_t i_cmd,
   input wire bsl_pkg::bsl_sense_rsp_t o_sense_rsp,
   input wire logic [119:0] o_ctrl_line,
   input wire logic i_std_irq,
   input wire logic o_std_irq,
   input wire logic [63:0] i_prio_req,
   input wire logic i_prio_ack,
   input wire logic o_prio_irq
);
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_b);
   wire set = i_cmd.valid && i_cmd.op == 2'h1;
   wire clr = i_cmd.valid && i_cmd.op == 2'h2;
   wire sns = i_cmd.valid && i_cmd.op == 2'h3;
   sequence lone_req;
      !o_prio_irq && i_prio_req == '0 ##1 $onehot(i_prio_req);
   endsequence
   set_line_a: assert property (set && i_cmd.addr < 120 |=> o_ctrl_line[$past(i_cmd.addr)])
      else $error("set");
   clear_line_a: assert property (clr && i_cmd.addr < 120 |=> !o_ctrl_line[$past(i_cmd.addr)])
      else $error("clear");
   line_hold_a: assert property (!set && !clr |=> $stable(o_ctrl_line)) else $error("hold");
   one_line_a: assert property (set || clr |=> $onehot0(o_ctrl_line ^ $past(o_ctrl_line)))
      else $error("one");
   sense_reply_a: assert property (sns |=> o_sense_rsp.valid) else $error("reply");
   std_follow_a: assert property ($stable(i_std_irq) [*4] |-> o_std_irq == i_std_irq)
      else $error("std");
   lone_pass_a: assert property (lone_req |-> ##[1:6] o_prio_irq) else $error("lone");
   ack_drop_a: assert property (o_prio_irq && i_prio_ack |=> !o_prio_irq) else $error("ack");
endmodule : bsl_link_asserts

// ### bsl_pkg.sv
// package for the binary signal link: sizes, opcodes, command carrier
package bsl_pkg;
   localparam int NUM_CTRL_BANKS = 15;
   localparam int NUM_SENSE_BANKS = 15;
   localparam int BANK_WIDTH = 8;
   localparam int NUM_CTRL = NUM_CTRL_BANKS * BANK_WIDTH;
   localparam int NUM_SENSE = NUM_SENSE_BANKS * BANK_WIDTH;
   localparam int NUM_PRIO_GROUPS = 16;
   localparam int PRIO_GROUP_WIDTH = 4;
   localparam int NUM_PRIO = NUM_PRIO_GROUPS * PRIO_GROUP_WIDTH;
   localparam int ADDR_W = 7;
   localparam int PRIO_ID_W = 6;
   localparam logic [ADDR_W-1:0] CTRL_LAST = 7'h77;
   localparam logic [ADDR_W-1:0] SENSE_LAST = 7'h77;

   typedef enum logic [1:0]
   {
      BSL_OP_NONE = 2'h0,
      BSL_OP_SET = 2'h1,
      BSL_OP_CLEAR = 2'h2,
      BSL_OP_SENSE = 2'h3
   } bsl_op_t;

   typedef struct packed
   {
      logic valid;
      bsl_op_t op;
      logic [ADDR_W-1:0] addr;
   } bsl_cmd_t;

   typedef struct packed
   {
      logic valid;
      logic state;
   } bsl_sense_rsp_t;
endpackage : bsl_pkg

// ### bsl_prio_arbiter.sv
// fixed-priority interrupt arbiter, lowest index highest priority
`timescale 1ns/1ns
module bsl_prio_arbiter
(
   input wire logic [bsl_pkg::NUM_PRIO-1:0] i_pending,
   output logic o_any,
   output logic [bsl_pkg::PRIO_ID_W-1:0] o_id
);
   logic [bsl_pkg::NUM_PRIO:0] seen;
   logic [bsl_pkg::PRIO_ID_W-1:0] pick [0:bsl_pkg::NUM_PRIO];

   assign seen[0] = 1'b0;
   assign pick[0] = '0;

   // chain: first set bit from index 0 wins
   genvar g;
   generate
      for (g = 0; g < bsl_pkg::NUM_PRIO; g++)
      begin : g_chain
         assign seen[g+1] = seen[g] | i_pending[g];
         assign pick[g+1] = (i_pending[g] && !seen[g]) ? 6'(g) : pick[g];
      end
   endgenerate

   assign o_any = seen[bsl_pkg::NUM_PRIO];
   assign o_id = pick[bsl_pkg::NUM_PRIO];
endmodule : bsl_prio_arbiter

// ### test_binary_signal_link.sv
// self-checking bench for the link
`timescale 1ns/1ns
module test_binary_signal_link;
   logic i_clock, i_rst_b, i_std_irq, i_prio_ack, o_std_irq, o_prio_irq, flag;
   bsl_pkg::bsl_cmd_t i_cmd;
   bsl_pkg::bsl_sense_rsp_t o_sense_rsp;
   logic [119:0] o_ctrl_line, i_sense_line, model;
   logic [63:0] i_prio_req;
   logic [5:0] o_prio_id;
   int miscompares, n_tests, a, b;
   int q[$] = '{60, 3, 7};
   bsl_link uut
   (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_cmd(i_cmd),
      .o_sense_rsp(o_sense_rsp),
      .o_ctrl_line(o_ctrl_line),
      .i_sense_line(i_sense_line),
      .i_std_irq(i_std_irq),
      .o_std_irq(o_std_irq),
      .i_prio_req(i_prio_req),
      .i_prio_ack(i_prio_ack),
      .o_prio_irq(o_prio_irq),
      .o_prio_id(o_prio_id)
   );
   bsl_host host (.i_clock(i_clock), .i_rsp(o_sense_rsp), .o_flag(flag));
   task automatic chk(input logic ok);
      n_tests++;
      if (ok !== 1'b1)
         $display("[ERR] %0t mismatch", $time);
      miscompares += int'(ok !== 1'b1);
   endtask : chk
   task automatic cmd(input int op, input int ad);
      i_cmd = {1'b1, 2'(op), 7'(ad)};
      @(negedge i_clock);
      i_cmd = '0;
      @(negedge i_clock);
   endtask : cmd
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   initial
   begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end
   initial
   begin
      #100000;
      miscompares++;
      complete_run();
   end
   initial
   begin
      {i_rst_b, i_std_irq, i_prio_ack, i_prio_req, i_cmd, model} = '0;
      a = $urandom(32'hb4189257);
      i_sense_line = 120'({$urandom, $urandom, $urandom, $urandom});
      repeat (20) @(negedge i_clock);
      chk(o_ctrl_line === '0 && o_prio_irq === 1'b0);
      i_rst_b = 1'b1;
      repeat (300)
      begin
         a = $urandom_range(127);
         b = $urandom_range(3);
         cmd(b, a);
         if (a < 120 && b inside {1, 2})
            model[a] = (b == 1);
         if (b == 3)
            chk(flag === (a < 120 && i_sense_line[a]));
         chk(o_ctrl_line === model);
      end
      i_std_irq = 1'b1;
      repeat (3) @(negedge i_clock);
      chk(o_std_irq === 1'b1);
      i_prio_req = 64'h1000_0000_0000_0000;
      foreach (q[k])
      begin
         if (k == 1)
            i_prio_req = 64'h88;
         repeat (12)
            if (o_prio_irq !== 1'b1)
               @(negedge i_clock);
         chk(o_prio_irq === 1'b1 && o_prio_id === 6'(q[k]));
         i_prio_ack = 1'b1;
         @(negedge i_clock);
         i_prio_ack = 1'b0;
         @(negedge i_clock);
      end
      i_std_irq = 1'b0;
      i_prio_req = '0;
      repeat (4) @(negedge i_clock);
      chk(o_std_irq === 1'b0);
      i_prio_req = 64'h3;
      repeat (12)
         if (o_prio_irq !== 1'b1)
            @(negedge i_clock);
      chk(o_prio_irq === 1'b1 && o_prio_id === 6'h00);
      // mid-run reset with one request still pending behind the presented one
      i_rst_b = 1'b0;
      i_prio_req = '0;
      model = '0;
      repeat (2) @(negedge i_clock);
      chk(o_ctrl_line === model && o_prio_irq === 1'b0);
      i_rst_b = 1'b1;
      repeat (8) @(negedge i_clock);
      chk(o_prio_irq === 1'b0 && o_ctrl_line === model);
      a = $urandom_range(119);
      cmd(1, a);
      model[a] = 1'b1;
      chk(o_ctrl_line === model);
      complete_run();
   end
endmodule : test_binary_signal_link
bind bsl_link bsl_link_asserts chk_u
(
   .i_clock(i_clock),
   .i_rst_b(i_rst_b),
   .i_cmd(i_cmd),
   .o_sense_rsp(o_sense_rsp),
   .o_ctrl_line(o_ctrl_line),
   .i_std_irq(i_std_irq),
   .o_std_irq(o_std_irq),
   .i_prio_req(i_prio_req),
   .i_prio_ack(i_prio_ack),
   .o_prio_irq(o_prio_irq)
);
